// file: rtl/pbm_basic_ctrl.sv
// pbm_basic_ctrl: basic mode control register with strap loading and mode outputs.
// assumes an upstream management decoder presents one-cycle read and write strobes.
`default_nettype none

// Operation
// R1 - speed code 10/01/00 gives 1000/100/10
// R2 - speed msb at bit 6, resets high
// R3 - bit 13 is speed code lsb
// R4 - negotiation enable loads strap at reset
// R5 - negotiation on ignores bits 13, 8
// R6 - power-down bit shuts transceiver, registers stay
// R7 - power-down is bit or low pin
// R8 - isolate bit detaches mac data interface
// R9 - restart write ignored when negotiation off
// R10 - restart reads one until started, self-clears
// R11 - writing restart zero does not cancel
// R12 - duplex loads strap, 1 full, 0 half
// R13 - collision test raises collision after transmit
// R14 - collision drops soon after transmit ends
// R15 - bits 5:0 read zero, writes dropped
// R16 - controller clears negotiation before forcing mode
module pbm_basic_ctrl
  import pbm_pkg::*;
(
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // straps, sampled while reset is held
  input  wire logic           strapAnEnable,
  input  wire logic           strapFullDuplex,
  // power-down pin, active low
  input  wire logic           power_down_pin_low,
  // register port
  input  wire logic           mgmtWrEn,
  input  wire logic           mgmtRdEn,
  input  wire logic [4:0]     mgmtAddr,
  input  wire logic [15:0]    mgmtWrData,
  output var  logic [15:0]    mgmtRdData,
  output var  logic           mgmtRdValid,
  // negotiation engine
  input  wire pbm_an_result_t anResult,
  input  wire logic           anStarted,
  output var  logic           anRestartReq,
  // datapath
  output var  pbm_mode_t      modeCfg,
  input  wire logic           txEn,
  output var  logic           col
);

  // register fields
  logic speedLsb_reg;
  logic anEn_reg;
  logic pwrDown_reg;
  logic isolate_reg;
  logic restart_reg;
  logic duplex_reg;
  logic colTest_reg;
  logic speedMsb_reg;

  logic        ctrlWrite;
  logic        pwrDown_next;
  logic        restart_next;
  logic [1:0]  speed_next;
  logic        duplex_next;
  logic [15:0] ctrlWord;

  // reserved codes leave the speed at the previous legal value
  function automatic logic [1:0] legal_speed(input logic [1:0] code, input logic [1:0] prev);
    legal_speed = (code == SPEED_RSVD) ? prev : code;
  endfunction

  assign ctrlWrite = mgmtWrEn && (mgmtAddr == CTRL_ADDR);

  // speed, isolate and collision test are plain read-write fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      speedLsb_reg <= SPEED_LSB_RST;
      speedMsb_reg <= SPEED_MSB_RST; // see R2
      isolate_reg  <= ISOLATE_RST;
      colTest_reg  <= COL_TEST_RST;
    end else if (ctrlWrite) begin
      speedLsb_reg <= mgmtWrData[SPEED_LSB_POS]; // see R3
      speedMsb_reg <= mgmtWrData[SPEED_MSB_POS]; // see R2
      isolate_reg  <= mgmtWrData[ISOLATE_POS];
      colTest_reg  <= mgmtWrData[COL_TEST_POS];
    end
  end

  // synchronous reset, so the strap levels are caught by the clocked reset branch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      anEn_reg   <= strapAnEnable; // see R4
      duplex_reg <= strapFullDuplex; // see R12
    end else if (ctrlWrite) begin
      anEn_reg   <= mgmtWrData[AN_EN_POS]; // see R4
      duplex_reg <= mgmtWrData[DUPLEX_POS]; // see R12
    end
  end

  // pin assertion sets the bit and wins over a clearing write
  always_comb begin
    pwrDown_next = pwrDown_reg;
    if (ctrlWrite) begin
      pwrDown_next = mgmtWrData[PWR_DOWN_POS];
    end
    if (!power_down_pin_low) begin
      pwrDown_next = 1'b1; // see R7
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwrDown_reg <= PWR_DOWN_RST;
    end else begin
      pwrDown_reg <= pwrDown_next;
    end
  end

  // restart: set by a one with negotiation enabled, cleared by the engine's start or by a write with negotiation off
  always_comb begin
    restart_next = restart_reg;
    if (anStarted) begin
      restart_next = 1'b0; // see R10
    end
    if (ctrlWrite && mgmtWrData[AN_RESTART_POS] && mgmtWrData[AN_EN_POS]) begin
      restart_next = 1'b1; // see R9
    end
    if (ctrlWrite && !mgmtWrData[AN_EN_POS]) begin
      restart_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restart_reg <= AN_RESTART_RST;
    end else begin
      restart_reg <= restart_next; // see R11
    end
  end

  // effective mode: forced fields count only with negotiation off
  always_comb begin
    if (anEn_reg) begin
      speed_next  = legal_speed(anResult.speed, modeCfg.speed); // see R5
      duplex_next = anResult.fullDuplex; // see R5
    end else begin
      speed_next  = legal_speed({speedMsb_reg, speedLsb_reg}, modeCfg.speed); // see R1
      duplex_next = duplex_reg; // see R12
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modeCfg <= '0;
    end else begin
      modeCfg.speed      <= speed_next;
      modeCfg.fullDuplex <= duplex_next;
      modeCfg.anEnable   <= anEn_reg;
      modeCfg.powerDown  <= pwrDown_reg | ~power_down_pin_low; // see R6, R7
      modeCfg.isolate    <= isolate_reg; // see R8
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      anRestartReq <= 1'b0;
    end else begin
      anRestartReq <= restart_next & anEn_reg;
    end
  end

  // readback; top two bits belong to logic outside this block and read zero
  always_comb begin
    ctrlWord = READ_ZERO; // see R15
    ctrlWord[SPEED_LSB_POS]  = speedLsb_reg;
    ctrlWord[AN_EN_POS]      = anEn_reg;
    ctrlWord[PWR_DOWN_POS]   = pwrDown_reg;
    ctrlWord[ISOLATE_POS]    = isolate_reg;
    ctrlWord[AN_RESTART_POS] = restart_reg; // see R10
    ctrlWord[DUPLEX_POS]     = duplex_reg;
    ctrlWord[COL_TEST_POS]   = colTest_reg;
    ctrlWord[SPEED_MSB_POS]  = speedMsb_reg;
  end

  // registers stay readable in power-down and isolation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mgmtRdData  <= READ_ZERO;
      mgmtRdValid <= 1'b0;
    end else begin
      mgmtRdValid <= mgmtRdEn; // see R6, R8
      if (mgmtRdEn) begin
        mgmtRdData <= (mgmtAddr == CTRL_ADDR) ? ctrlWord : READ_ZERO;
      end
    end
  end

  pbm_col_test u_col_test (
    .clk    (clk),
    .rst_n  (rst_n),
    .testEn (colTest_reg),
    .txEn   (txEn),
    .col    (col)
  );

  a_speed_forced: assert property (@(posedge clk) disable iff (!rst_n) // see R1
    (!anEn_reg && {speedMsb_reg, speedLsb_reg} != SPEED_RSVD)
      |=> modeCfg.speed == $past({speedMsb_reg, speedLsb_reg}))
    else $error("forced speed not applied");

  a_speed_msb_write: assert property (@(posedge clk) disable iff (!rst_n) // see R2
    ctrlWrite |=> speedMsb_reg == $past(mgmtWrData[SPEED_MSB_POS]))
    else $error("speed msb not written");

  a_speed_lsb_write: assert property (@(posedge clk) disable iff (!rst_n) // see R3
    ctrlWrite |=> speedLsb_reg == $past(mgmtWrData[SPEED_LSB_POS]))
    else $error("speed lsb not written");

  a_strap_load: assert property (@(posedge clk) // see R4, R12
    !rst_n |=> anEn_reg == $past(strapAnEnable) && duplex_reg == $past(strapFullDuplex))
    else $error("strap not loaded at reset");

  a_an_ignores_force: assert property (@(posedge clk) disable iff (!rst_n) // see R5
    (anEn_reg && anResult.speed != SPEED_RSVD)
      |=> modeCfg.speed == $past(anResult.speed) && modeCfg.fullDuplex == $past(anResult.fullDuplex))
    else $error("forced bits used while negotiating");

  a_pin_sets_bit: assert property (@(posedge clk) disable iff (!rst_n) // see R7
    !power_down_pin_low |=> pwrDown_reg && modeCfg.powerDown)
    else $error("power-down pin did not set the bit");

  a_power_down_or: assert property (@(posedge clk) disable iff (!rst_n) // see R6
    ##1 modeCfg.powerDown == ($past(pwrDown_reg) | ~$past(power_down_pin_low)))
    else $error("effective power-down wrong");

  a_isolate_follow: assert property (@(posedge clk) disable iff (!rst_n) // see R8
    (ctrlWrite && mgmtAddr == CTRL_ADDR) |=> ##1 modeCfg.isolate == $past(mgmtWrData[ISOLATE_POS], 2))
    else $error("isolate not applied");

  a_restart_ignored: assert property (@(posedge clk) disable iff (!rst_n) // see R9
    (ctrlWrite && !mgmtWrData[AN_EN_POS]) |=> !restart_reg)
    else $error("restart accepted with negotiation off");

  a_restart_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R10, R11
    (restart_reg && !anStarted && !(ctrlWrite && !mgmtWrData[AN_EN_POS])) |=> restart_reg)
    else $error("restart cleared before start");

  a_restart_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R10
    (anStarted && !ctrlWrite) |=> !restart_reg)
    else $error("restart did not self-clear");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // see R15
    mgmtRdValid |-> mgmtRdData[5:0] == 6'h00 && mgmtRdData[15:14] == 2'h0)
    else $error("reserved bits read nonzero");

  a_reserved_keep: assert property (@(posedge clk) disable iff (!rst_n) // see R1
    (!anEn_reg && {speedMsb_reg, speedLsb_reg} == SPEED_RSVD) |=> $stable(modeCfg.speed))
    else $error("reserved speed code changed the speed");

  a_forced_duplex: assert property (@(posedge clk) disable iff (!rst_n) // see R12
    !anEn_reg |=> modeCfg.fullDuplex == $past(duplex_reg))
    else $error("forced duplex not applied");

  a_an_duplex_write: assert property (@(posedge clk) disable iff (!rst_n) // see R4, R12
    ctrlWrite |=> anEn_reg == $past(mgmtWrData[AN_EN_POS]) && duplex_reg == $past(mgmtWrData[DUPLEX_POS]))
    else $error("negotiation enable or duplex not written");

  a_power_bit_write: assert property (@(posedge clk) disable iff (!rst_n) // see R6
    (ctrlWrite && power_down_pin_low) |=> pwrDown_reg == $past(mgmtWrData[PWR_DOWN_POS]))
    else $error("power-down bit not written");

  a_isolate_write: assert property (@(posedge clk) disable iff (!rst_n) // see R8
    ctrlWrite |=> isolate_reg == $past(mgmtWrData[ISOLATE_POS]))
    else $error("isolate bit not written");

  a_restart_set: assert property (@(posedge clk) disable iff (!rst_n) // see R9
    (ctrlWrite && mgmtWrData[AN_RESTART_POS] && mgmtWrData[AN_EN_POS]) |=> restart_reg)
    else $error("restart not accepted");

  a_restart_req_pend: assert property (@(posedge clk) disable iff (!rst_n) // see R10
    anRestartReq |-> restart_reg)
    else $error("restart request without pending restart");

  a_restart_req_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R9
    (ctrlWrite && !mgmtWrData[AN_EN_POS]) |=> !anRestartReq)
    else $error("restart request with negotiation off");

  a_col_test_write: assert property (@(posedge clk) disable iff (!rst_n) // see R13
    ctrlWrite |=> colTest_reg == $past(mgmtWrData[COL_TEST_POS]))
    else $error("collision test bit not written");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n) // see R15
    (mgmtRdEn && mgmtAddr != CTRL_ADDR) |=> mgmtRdData == READ_ZERO)
    else $error("unmapped read not zero");

  a_readback_word: assert property (@(posedge clk) disable iff (!rst_n) // see R6, R8
    (mgmtRdEn && mgmtAddr == CTRL_ADDR) |=> mgmtRdData == $past(ctrlWord))
    else $error("readback word wrong");

  a_rd_valid_pulse: assert property (@(posedge clk) disable iff (!rst_n) // see R6
    mgmtRdEn |=> mgmtRdValid)
    else $error("read not answered");

endmodule

`default_nettype wire

// file: rtl/pbm_pkg.sv
// pbm_pkg: constants and carrier types for the basic mode control register block.
// assumes a single 125 MHz clock and a register port fed by the management frame decoder.
`default_nettype none

package pbm_pkg;

  // register map
  localparam logic [4:0]  CTRL_ADDR        = 5'h00;

  // field positions inside the control word
  localparam int          SPEED_LSB_POS    = 13;
  localparam int          AN_EN_POS        = 12;
  localparam int          PWR_DOWN_POS     = 11;
  localparam int          ISOLATE_POS      = 10;
  localparam int          AN_RESTART_POS   = 9;
  localparam int          DUPLEX_POS       = 8;
  localparam int          COL_TEST_POS     = 7;
  localparam int          SPEED_MSB_POS    = 6;

  // reset values of the plain fields; the negotiation enable and duplex come from straps
  localparam logic        SPEED_LSB_RST    = 1'h0;
  localparam logic        PWR_DOWN_RST     = 1'h0;
  localparam logic        ISOLATE_RST      = 1'h0;
  localparam logic        AN_RESTART_RST   = 1'h0;
  localparam logic        COL_TEST_RST     = 1'h0;
  localparam logic        SPEED_MSB_RST    = 1'h1;
  localparam logic [15:0] READ_ZERO        = 16'h0000;

  // speed codes, msb:lsb
  localparam logic [1:0]  SPEED_10         = 2'h0;
  localparam logic [1:0]  SPEED_100        = 2'h1;
  localparam logic [1:0]  SPEED_1000       = 2'h2;
  localparam logic [1:0]  SPEED_RSVD       = 2'h3;

  // collision test timing, in bit times at the fastest rate
  localparam int          CLK_PERIOD_PS    = 8000;
  localparam int          BIT_TIME_PS      = 1000;
  localparam int          COL_ON_BITS      = 512;
  localparam int          COL_OFF_BITS     = 4;
  localparam int          COL_ON_RAW       = (COL_ON_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
  localparam int          COL_OFF_RAW      = (COL_OFF_BITS * BIT_TIME_PS) / CLK_PERIOD_PS;
  localparam int          COL_ON_CYC       = (COL_ON_RAW < 1) ? 1 : COL_ON_RAW;
  localparam int          COL_OFF_CYC      = (COL_OFF_RAW < 1) ? 1 : COL_OFF_RAW;

  // effective operating mode handed to the datapath
  typedef struct packed {
    logic [1:0] speed;
    logic       fullDuplex;
    logic       anEnable;
    logic       powerDown;
    logic       isolate;
  } pbm_mode_t;

  // result of the negotiation engine
  typedef struct packed {
    logic [1:0] speed;
    logic       fullDuplex;
  } pbm_an_result_t;

endpackage

`default_nettype wire

// file: rtl/pbm_col_test.sv
// pbm_col_test: collision test loop, echoes transmit enable onto the collision output.
// assumes txEn is synchronous to clk; enable comes from the control register.
`default_nettype none

module pbm_col_test
  import pbm_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic testEn,
  // mac side
  input  wire logic txEn,
  output var  logic col
);

  // one flop meets only the on bound: assert after one cycle, release after one cycle, 8 bit times against the 4-bit off bound
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      col <= 1'b0;
    end else begin
      col <= testEn & txEn; // see R13, R14
    end
  end

  a_col_on_bound: assert property (@(posedge clk) disable iff (!rst_n) // see R13
    (testEn && txEn) |=> col)
    else $error("collision not raised after transmit enable");

  a_col_off_bound: assert property (@(posedge clk) disable iff (!rst_n) // see R14
    $fell(txEn) |=> !col)
    else $error("collision not released after transmit enable fell");

endmodule

`default_nettype wire

// file: tb/pbm_mgmt_model.sv
// pbm_mgmt_model: management controller model, one strobe-based access per call.
// assumes the register port samples on the rising edge of clk.
`default_nettype none

module pbm_mgmt_model
  import pbm_pkg::*;
(
  // clock
  input  wire logic        clk,
  // register port
  output var  logic        mgmtWrEn,
  output var  logic        mgmtRdEn,
  output var  logic [4:0]  mgmtAddr,
  output var  logic [15:0] mgmtWrData,
  input  wire logic [15:0] mgmtRdData,
  input  wire logic        mgmtRdValid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    mgmtWrEn = 1'b0;
    mgmtRdEn = 1'b0;
    mgmtAddr = 5'h1f;
    mgmtWrData = 16'hffff;
  end

  // released lines show the inverse so a stale value cannot pass for a fresh one
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    mgmtAddr = a;
    mgmtWrData = d;
    mgmtWrEn = 1'b1;
    @(negedge clk);
    mgmtWrEn = 1'b0;
    mgmtAddr = ~a;
    mgmtWrData = ~d;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    mgmtAddr = a;
    mgmtRdEn = 1'b1;
    @(negedge clk);
    mgmtRdEn = 1'b0;
    mgmtAddr = ~a;
    while (mgmtRdValid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    d = (mgmtRdValid === 1'b1) ? mgmtRdData : 16'hxxxx;
  endtask
endmodule

`default_nettype wire

// file: tb/tb_pbm_basic_ctrl.sv
// tb_pbm_basic_ctrl: directed tests of the basic mode control register.
// assumes the management model drives the register port; bench drives straps, pin, engine and mac.
`default_nettype none

module tb_pbm_basic_ctrl
  import pbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           strapAn = 1'b1;
  logic           strapFd = 1'b0;
  logic           pinLow_n = 1'b1;
  logic           mgmtWrEn, mgmtRdEn, mgmtRdValid, anRestartReq, col;
  logic [4:0]     mgmtAddr;
  logic [15:0]    mgmtWrData, mgmtRdData, rdw;
  pbm_an_result_t anResult = '{speed: SPEED_100, fullDuplex: 1'b1};
  logic           anStarted = 1'b0;
  logic           txEn = 1'b0;
  pbm_mode_t      modeCfg;
  int             error_cnt = 0;
  int             checked = 0;
  logic [1:0]     codes [3] = '{SPEED_10, SPEED_100, SPEED_1000};

  initial forever #4 clk = ~clk;

  pbm_mgmt_model mgr_i (.clk(clk), .mgmtWrEn(mgmtWrEn), .mgmtRdEn(mgmtRdEn), .mgmtAddr(mgmtAddr),
    .mgmtWrData(mgmtWrData), .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid));

  pbm_basic_ctrl pbm_basic_ctrl_i (.clk(clk), .rst_n(rst_n), .strapAnEnable(strapAn),
    .strapFullDuplex(strapFd), .power_down_pin_low(pinLow_n), .mgmtWrEn(mgmtWrEn), .mgmtRdEn(mgmtRdEn),
    .mgmtAddr(mgmtAddr), .mgmtWrData(mgmtWrData), .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid),
    .anResult(anResult), .anStarted(anStarted), .anRestartReq(anRestartReq), .modeCfg(modeCfg),
    .txEn(txEn), .col(col));

  task automatic chkWord(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkBit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // called on a falling edge; holds reset over four rising edges
  task automatic rstDut(input logic an, input logic fd);
    strapAn = an;
    strapFd = fd;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
  endtask

  // write then let the mode output settle two edges later
  task automatic wrSettle(input logic [15:0] d);
    mgr_i.wr(CTRL_ADDR, d);
    repeat (2) @(negedge clk);
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200us;
    error_cnt++;
    summarize();
  end

  initial begin
    rstDut(1'b1, 1'b0);
    mgr_i.rd(CTRL_ADDR, rdw);
    chkWord("reset word", 16'h1040, rdw);
    $display("test reset done");
    // negotiation cleared before any forced mode
    wrSettle(16'h0000);
    for (int i = 0; i < 3; i++) begin
      wrSettle({2'h0, codes[i][0], 4'h0, i[0], 1'b0, codes[i][1], 6'h3f});
      chkWord("forced speed", {14'h0, codes[i]}, {14'h0, modeCfg.speed});
      chkBit("forced duplex", i[0], modeCfg.fullDuplex);
      mgr_i.rd(CTRL_ADDR, rdw);
      chkWord("forced word", {2'h0, codes[i][0], 4'h0, i[0], 1'b0, codes[i][1], 6'h00}, rdw);
    end
    // reserved code leaves the last legal speed in force
    wrSettle(16'h2040);
    chkWord("reserved speed", {14'h0, SPEED_1000}, {14'h0, modeCfg.speed});
    chkBit("an off", 1'b0, modeCfg.anEnable);
    $display("test forced mode done");
    wrSettle(16'h1040);
    chkWord("an speed", {14'h0, SPEED_100}, {14'h0, modeCfg.speed});
    chkBit("an duplex", 1'b1, modeCfg.fullDuplex);
    chkBit("an on", 1'b1, modeCfg.anEnable);
    wrSettle(16'h1200);
    chkBit("restart req", 1'b1, anRestartReq);
    wrSettle(16'h1000);
    mgr_i.rd(CTRL_ADDR, rdw);
    chkWord("restart kept", 16'h1200, rdw);
    chkBit("restart req kept", 1'b1, anRestartReq);
    anStarted = 1'b1;
    @(negedge clk);
    anStarted = 1'b0;
    repeat (2) @(negedge clk);
    chkBit("restart req cleared", 1'b0, anRestartReq);
    mgr_i.rd(CTRL_ADDR, rdw);
    chkWord("restart cleared", 16'h1000, rdw);
    wrSettle(16'h0200);
    chkBit("restart ignored", 1'b0, anRestartReq);
    mgr_i.rd(CTRL_ADDR, rdw);
    chkWord("restart ignored word", 16'h0000, rdw);
    $display("test restart done");
    pinLow_n = 1'b0;
    @(negedge clk);
    pinLow_n = 1'b1;
    mgr_i.rd(CTRL_ADDR, rdw);
    chkWord("pin sets bit", 16'h0800, rdw);
    chkBit("pin power down", 1'b1, modeCfg.powerDown);
    wrSettle(16'h0000);
    chkBit("power up", 1'b0, modeCfg.powerDown);
    wrSettle(16'h0c00);
    chkBit("bit power down", 1'b1, modeCfg.powerDown);
    chkBit("isolate", 1'b1, modeCfg.isolate);
    mgr_i.rd(CTRL_ADDR, rdw);
    chkWord("read while isolated", 16'h0c00, rdw);
    $display("test power and isolate done");
    wrSettle(16'h0000);
    chkBit("isolate off", 1'b0, modeCfg.isolate);
    txEn = 1'b1;
    repeat (3) @(negedge clk);
    chkBit("no test col", 1'b0, col);
    txEn = 1'b0;
    wrSettle(16'h0080);
    txEn = 1'b1;
    repeat (COL_ON_CYC + 1) @(negedge clk);
    chkBit("col on", 1'b1, col);
    txEn = 1'b0;
    repeat (COL_OFF_CYC + 1) @(negedge clk);
    chkBit("col off", 1'b0, col);
    $display("test collision done");
    mgr_i.wr(5'h01, 16'hffff);
    mgr_i.rd(5'h01, rdw);
    chkWord("unmapped read", READ_ZERO, rdw);
    mgr_i.rd(CTRL_ADDR, rdw);
    chkWord("unmapped write", 16'h0080, rdw);
    rstDut(1'b0, 1'b1);
    mgr_i.rd(CTRL_ADDR, rdw);
    chkWord("restrap word", 16'h0140, rdw);
    chkBit("restrap duplex", 1'b1, modeCfg.fullDuplex);
    chkBit("restrap an off", 1'b0, modeCfg.anEnable);
    $display("test map and restrap done");
    summarize();
  end
endmodule

`default_nettype wire
